// *** hdl/fast_link_down_monitor.sv ***
/*
 * Link-loss monitor of a 10/100 PHY receive path: default long window
 * or fast 10 us windows with four criteria, plus a Wishbone register pair.
 * Assumes all event inputs come from logic on clk_i, one bit per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module fast_link_down_monitor
	import fld_pkg::*;
#(
	parameter int unsigned DEF_WIN = fld_pkg::DEF_WIN_CYC
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Receive path indications.
	input  wire logic        speed100_i,
	input  wire logic        rx_err_i,
	input  wire logic        sym_valid_i,
	input  wire logic [1:0]  sym_i,
	input  wire logic        sq_low_i,
	input  wire logic        energy_lost_i,
	// Link verdict.
	output logic             link_drop_o
);
	import fld_pkg::*;

	// The timer must hold the longer of the two windows, so that a short
	// default window chosen for quick runs never truncates the fast one.
	localparam int unsigned WIN_MAX =
		(DEF_WIN > FAST_WIN_CYC) ? DEF_WIN : FAST_WIN_CYC;
	localparam int unsigned WIN_W = $clog2(WIN_MAX + 1);
	localparam logic [WIN_W-1:0] FAST_LAST = WIN_W'(FAST_WIN_CYC - 1);
	localparam logic [WIN_W-1:0] DEF_LAST  = WIN_W'(DEF_WIN - 1);

	typedef struct packed {
		logic [15:0]      ctrl;
		logic [15:0]      status;
		logic             ack;
		logic [31:0]      rdata;
		logic [WIN_W-1:0] win;
		logic [1:0]       prev_sym;
		logic [1:0]       last_nz;
		logic             sq_prev;
		logic             drop;
	} mon_state_t;

	mon_state_t s_q;
	mon_state_t s_d;

	crit_if rx_c ();
	crit_if ml_c ();
	crit_if sq_c ();

	// A symbol breaks the three-level rule when it is illegal, jumps
	// between the two non-zero levels, or repeats the last non-zero level
	// after a zero instead of alternating.
	function automatic logic mlt3_bad(input logic [1:0] prev,
			input logic [1:0] last_nz, input logic [1:0] cur);
		logic cur_nz;
		cur_nz = (cur != SYM_ZERO);
		mlt3_bad = 1'b0;
		if (cur != SYM_ZERO && cur != SYM_PLUS && cur != SYM_MINUS) begin
			mlt3_bad = 1'b1;
		end else if (cur_nz && prev != SYM_ZERO && cur != prev) begin
			mlt3_bad = 1'b1;
		end else if (cur_nz && prev == SYM_ZERO && cur == last_nz) begin
			mlt3_bad = 1'b1;
		end
	endfunction

	// Sixteen-bit register write with byte lanes.
	function automatic logic [15:0] lane_wr(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] sel);
		lane_wr = old;
		if (sel[0]) begin
			lane_wr[7:0] = d[7:0];
		end
		if (sel[1]) begin
			lane_wr[15:8] = d[15:8];
		end
	endfunction

	logic       fast_mode;
	logic       win_end;
	logic       bus_req;
	logic [3:0] hit;
	logic       wr_ctrl;
	logic       wr_stat;
	logic [15:0] clr_mask;
	logic [15:0] set_mask;

	assign fast_mode = |s_q.ctrl[N_CRIT-1:0];
	assign win_end   = fast_mode ? (s_q.win == FAST_LAST)
	                             : (s_q.win == DEF_LAST);
	assign bus_req   = cyc_i && stb_i && !s_q.ack;
	assign wr_ctrl   = bus_req && we_i
	                   && adr_i == {LINK_DOWN_CONTROL_IDX[5:0], 2'b00};
	assign wr_stat   = bus_req && we_i
	                   && adr_i == {LINK_DROP_STATUS_IDX[5:0], 2'b00};

	// Event feeds and window clears for the three counting criteria.
	assign rx_c.ev  = rx_err_i && s_q.ctrl[F_RXERR];
	assign ml_c.ev  = s_q.ctrl[F_MLT3] && speed100_i && sym_valid_i
	                  && mlt3_bad(s_q.prev_sym, s_q.last_nz, sym_i);
	assign sq_c.ev  = s_q.ctrl[F_SQ] && sq_low_i && !s_q.sq_prev;
	assign rx_c.clr = win_end || s_q.drop;
	assign ml_c.clr = win_end || s_q.drop;
	assign sq_c.clr = win_end || s_q.drop;

	// Any enabled criterion that is met drops the link.
	assign hit[F_RXERR]  = rx_c.met;
	assign hit[F_MLT3]   = ml_c.met;
	assign hit[F_SQ]     = sq_c.met;
	assign hit[F_ENERGY] = s_q.ctrl[F_ENERGY] && energy_lost_i;

	occ_counter #(.LIMIT(RXERR_LIMIT), .W(6)) u_rx (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.c     (rx_c.counter)
	);
	occ_counter #(.LIMIT(MLT3_LIMIT), .W(5)) u_ml (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.c     (ml_c.counter)
	);
	occ_counter #(.LIMIT(SQ_LIMIT), .W(5)) u_sq (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.c     (sq_c.counter)
	);

	// Status masks: a cause that arrives in the clearing cycle survives.
	always_comb begin
		set_mask = '0;
		clr_mask = '0;
		if (fast_mode) begin
			set_mask[N_CRIT-1:0] = hit;
		end else if (win_end && energy_lost_i) begin
			set_mask[F_DEFWIN] = 1'b1;
		end
		if (wr_stat) begin
			clr_mask = lane_wr(16'h0000, dat_i, sel_i);
		end
	end

	// Next state: window timer, line history, registers and bus answer.
	always_comb begin
		s_d      = s_q;
		s_d.ack  = bus_req;
		s_d.drop = 1'b0;
		s_d.sq_prev = sq_low_i;
		if (win_end || s_q.drop) begin
			s_d.win = '0;
		end else begin
			s_d.win = s_q.win + WIN_W'(1);
		end
		// The default window only drops when loss lasted all of it.
		if (!fast_mode) begin
			if (!energy_lost_i) begin
				s_d.win = '0;
			end
			s_d.drop = win_end && energy_lost_i;
		end else begin
			s_d.drop = |hit;
		end
		if (sym_valid_i) begin
			s_d.prev_sym = sym_i;
			if (sym_i != SYM_ZERO) begin
				s_d.last_nz = sym_i;
			end
		end
		if (wr_ctrl) begin
			s_d.ctrl = lane_wr(s_q.ctrl, dat_i, sel_i);
		end
		s_d.status = (s_q.status & ~clr_mask) | set_mask;
		s_d.rdata = '0;
		if (bus_req && !we_i) begin
			if (adr_i == {LINK_DOWN_CONTROL_IDX[5:0], 2'b00}) begin
				s_d.rdata = {16'h0000, s_q.ctrl};
			end else if (adr_i == {LINK_DROP_STATUS_IDX[5:0], 2'b00}) begin
				s_d.rdata = {16'h0000, s_q.status};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q        <= '0;
			s_q.ctrl   <= CONTROL_RST;
			s_q.status <= STATUS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Answers come from flip-flops; unmapped reads return zero.
	assign dat_o       = s_q.rdata;
	assign ack_o       = s_q.ack;
	assign link_drop_o = s_q.drop;

endmodule // fast_link_down_monitor

`default_nettype wire

// *** hdl/occ_counter.sv ***
/*
 * Counts occurrences of one criterion inside the current window.
 * Assumes the monitor clears it at every window start and every drop.
 */
`timescale 1ns/1ps
`default_nettype none

module occ_counter #(
	parameter int unsigned LIMIT = 20,
	parameter int unsigned W     = 6
) (
	// Clock and reset.
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// Monitor side.
	crit_if.counter     c
);
	import fld_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
	} occ_state_t;

	occ_state_t s_q;
	occ_state_t s_d;

	localparam logic [W-1:0] LAST = W'(LIMIT - 1);

	// The occurrence that reaches the limit reports at once.
	assign c.met = c.ev && (s_q.cnt == LAST);

	// Clear wins over counting, so no count leaks into the next window.
	always_comb begin
		s_d = s_q;
		if (c.clr) begin
			s_d.cnt = '0;
		end else if (c.ev && s_q.cnt != LAST) begin
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule // occ_counter

`default_nettype wire

// *** shared/crit_if.sv ***
/*
 * Carrier between the monitor and one occurrence counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface crit_if;
	logic ev;   // One occurrence this cycle.
	logic clr;  // Restart the count.
	logic met;  // Threshold reached by this occurrence.
	modport counter (input ev, input clr, output met);
	modport monitor (output ev, output clr, input met);
endinterface

`default_nettype wire

// *** shared/fld_pkg.sv ***
/*
 * Constants for the fast link-down monitor: register map, field layout,
 * reset values and timing counts.
 * Assumes a 20 MHz core clock and word-wide Wishbone register access.
 */
package fld_pkg;

	// Clock period and the derived window lengths.
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned FAST_WIN_US   = 10;
	localparam int unsigned FAST_WIN_CYC  = (FAST_WIN_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned DEF_WIN_MS    = 1;
	localparam int unsigned DEF_WIN_CYC   =
		(DEF_WIN_MS * 1000000) / CLK_PERIOD_NS;

	// Occurrence thresholds per window.
	localparam int unsigned RXERR_LIMIT = 32;
	localparam int unsigned MLT3_LIMIT  = 20;
	localparam int unsigned SQ_LIMIT    = 20;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] LINK_DOWN_CONTROL_IDX = 8'h0B;
	localparam logic [7:0] LINK_DROP_STATUS_IDX  = 8'h0F;

	// Field positions shared by the enable and the cause registers, except the cause-only F_DEFWIN.
	localparam int unsigned F_RXERR  = 0;
	localparam int unsigned F_MLT3   = 1;
	localparam int unsigned F_SQ     = 2;
	localparam int unsigned F_ENERGY = 3;
	localparam int unsigned F_DEFWIN = 4;
	localparam int unsigned N_CRIT   = 4;

	// Reset values.
	localparam logic [15:0] CONTROL_RST = 16'h0000;
	localparam logic [15:0] STATUS_RST  = 16'h0000;

	// Three-level line symbol codes.
	localparam logic [1:0] SYM_ZERO  = 2'h0;
	localparam logic [1:0] SYM_PLUS  = 2'h1;
	localparam logic [1:0] SYM_MINUS = 2'h3;

endpackage

// *** testbench/fld_checker_properties.sv ***
/* Port checker of the link-down monitor.
   Assumes binding to the monitor; enables are shadowed from bus writes. */
`timescale 1ns/1ps
`default_nettype none
module fld_checker #(parameter int unsigned DEF_WIN = 50) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        speed100_i,
	input wire logic        rx_err_i,
	input wire logic        sym_valid_i,
	input wire logic        sq_low_i,
	input wire logic        energy_lost_i,
	input wire logic        link_drop_o
);
	logic [3:0] ctl_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s; cyc_i && stb_i && !ack_o; endsequence
	sequence rd_other_s;
		cyc_i && stb_i && !ack_o && !we_i && adr_i != 8'h2C
			&& adr_i != 8'h3C;
	endsequence
	sequence energy_s; ctl_q[3] && energy_lost_i; endsequence
	sequence quiet_s;
		!rx_err_i && !sym_valid_i && !sq_low_i
			&& !(energy_lost_i && (ctl_q[3] || ctl_q == 4'h0));
	endsequence
	sequence slow_s; ctl_q == 4'h2 && !speed100_i; endsequence
	sequence dflt_drop_s; ctl_q == 4'h0 && link_drop_o; endsequence
	// Shadow of the enables; a write lands at the edge that takes it.
	always_ff @(posedge clk_i) begin
		if (rst_i) ctl_q <= 4'h0;
		else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h2C)
			ctl_q <= dat_i[3:0];
	end
	chk_ack_taken: assert property (req_s |=> ack_o)
		else $error("no ack");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("long ack");
	chk_read_zero: assert property (rd_other_s |=> dat_o == 32'h0)
		else $error("unmapped data");
	chk_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("stray data");
	chk_energy_drop: assert property (energy_s |=> link_drop_o)
		else $error("energy ignored");
	chk_no_cause: assert property (quiet_s |=> !link_drop_o)
		else $error("drop without cause");
	chk_slow_code: assert property (slow_s |=> !link_drop_o)
		else $error("code error at low speed");
	chk_default_win: assert property (dflt_drop_s
		|-> $past(energy_lost_i))
		else $error("default drop without loss");
endmodule // fld_checker
bind fast_link_down_monitor fld_checker #(.DEF_WIN(DEF_WIN)) i_chk (
	.clk_i         (clk_i),
	.rst_i         (rst_i),
	.cyc_i         (cyc_i),
	.stb_i         (stb_i),
	.we_i          (we_i),
	.adr_i         (adr_i),
	.dat_i         (dat_i),
	.dat_o         (dat_o),
	.ack_o         (ack_o),
	.speed100_i    (speed100_i),
	.rx_err_i      (rx_err_i),
	.sym_valid_i   (sym_valid_i),
	.sq_low_i      (sq_low_i),
	.energy_lost_i (energy_lost_i),
	.link_drop_o   (link_drop_o)
);
`default_nettype wire

// *** testbench/remote_partner.sv ***
/* Remote link partner model driving the receive indications.
   Assumes the bench picks a mode just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module remote_partner (
	input  wire logic       clk_i,
	input  wire logic [2:0] mode_i,
	output logic            rx_err_o,
	output logic            sym_valid_o,
	output logic      [1:0] sym_o,
	output logic            sq_low_o,
	output logic            energy_lost_o
);
	logic ph_q = 1'b0; // Known start, so the symbol stream is never unknown.
	// Each mode from one to five stresses one criterion; idle symbols keep changing.
	// Mode five swings straight between the two non-zero levels.
	always @(posedge clk_i) begin
		ph_q <= ~ph_q;
		rx_err_o <= (mode_i == 3'h1);
		sym_valid_o <= (mode_i == 3'h2) || (mode_i == 3'h5);
		sym_o <= (mode_i == 3'h2) ? 2'h2 : (ph_q ? 2'h1 : 2'h3);
		sq_low_o <= (mode_i == 3'h3) && (sq_low_o !== 1'b1);
		energy_lost_o <= (mode_i == 3'h4);
	end
endmodule // remote_partner
`default_nettype wire

// *** testbench/tb.sv ***
/* Self-checking bench of the link-down monitor.
   Assumes the bound checker and the remote partner model. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fld_pkg::*;
	localparam int unsigned DW = 50; // Short default window keeps runs brief.
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic        we_i = 1'b0, speed100_i = 1'b1;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, rd, r;
	logic [2:0]  mode = 3'h0;
	logic [1:0]  sym;
	logic        ack_o, link_drop_o, rx_err, symv, sq, en;
	int          errors = 0, tests_run = 0, drops = 0, n, i;
	// Cycles from a mode change to a seen drop on a fresh window: partner
	// register, drop register and tally add one each; quality rises on
	// every second cycle.
	int          ex[4] = '{RXERR_LIMIT + 3, MLT3_LIMIT + 3,
		2 * SQ_LIMIT + 2, 4};
	always #25 clk_i = ~clk_i;
	// Drops are tallied so waits need not catch a one-cycle pulse.
	always @(posedge clk_i) if (link_drop_o === 1'b1) drops <= drops + 1;
	fast_link_down_monitor #(.DEF_WIN(DW)) i_dut (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .speed100_i(speed100_i), .rx_err_i(rx_err),
		.sym_valid_i(symv), .sym_i(sym), .sq_low_i(sq),
		.energy_lost_i(en), .link_drop_o(link_drop_o));
	remote_partner i_far (.clk_i(clk_i), .mode_i(mode), .rx_err_o(rx_err),
		.sym_valid_o(symv), .sym_o(sym), .sq_low_o(sq), .energy_lost_o(en));
	task automatic check(input logic [31:0] s, e, input string w);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		for (k = 0; k < 20 && ack_o !== 1'b1; k++) @(posedge clk_i);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		if (k == 20) begin
			errors++;
			stop_test();
		end else @(posedge clk_i);
	endtask
	// Runs one partner mode until a drop or the limit, then rests.
	task automatic run(input logic [2:0] m, input int lim, input logic x);
		int d0;
		d0 = drops;
		mode <= m;
		for (n = 0; n < lim && drops == d0; n++) @(posedge clk_i);
		mode <= 3'h0;
		if (x && drops == d0) begin
			errors++;
			stop_test();
		end else check(32'(drops != d0), 32'(x), "drop");
		repeat (4) @(posedge clk_i);
	endtask
	initial begin
		void'($urandom(32'hB28FF117));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h2C, 32'h0);
		check(rd, 32'h0, "control");
		wb(1'b1, 8'h40, 32'hFFFF);
		wb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0, "unmapped");
		for (i = 0; i < 4; i++) begin
			wb(1'b1, 8'h2C, 32'h0); // Parks the window timer at zero.
			wb(1'b1, 8'h2C, 32'h1 << i);
			run(3'(i + 1), 300, 1'b1);
			check(32'(n), 32'(ex[i]), "count");
			wb(1'b0, 8'h3C, 32'h0);
			check(rd, 32'h1 << i, "cause");
			wb(1'b1, 8'h3C, 32'h1F);
			$display("criterion %0d done", i);
		end
		// Bursts in different windows must not add up.
		wb(1'b1, 8'h2C, 32'h1);
		run(3'h1, 20, 1'b0);
		run(3'h0, 250, 1'b0);
		run(3'h1, 20, 1'b0);
		speed100_i <= 1'b0;
		wb(1'b1, 8'h2C, 32'h2);
		run(3'h2, 100, 1'b0);
		speed100_i <= 1'b1;
		// Direct swings between the non-zero levels break the line code.
		wb(1'b1, 8'h2C, 32'h0);
		wb(1'b1, 8'h2C, 32'h2);
		run(3'h5, 100, 1'b1);
		check(32'(n), 32'(MLT3_LIMIT + 3), "swing count");
		wb(1'b0, 8'h3C, 32'h0);
		check(rd, 32'h2, "swing cause");
		wb(1'b1, 8'h3C, 32'h1F);
		wb(1'b1, 8'h2C, 32'h1);
		run(3'h4, 100, 1'b0);
		wb(1'b1, 8'h2C, 32'h0);
		run(3'h4, 100, 1'b1);
		check(32'(n), 32'(DW + 3), "window");
		wb(1'b0, 8'h3C, 32'h0);
		check(rd, 32'h10, "default cause");
		$display("windows done");
		repeat (4) begin
			r = $urandom;
			wb(1'b1, 8'h2C, r);
			wb(1'b0, 8'h2C, 32'h0);
			check({28'h0, rd[3:0]}, {28'h0, r[3:0]}, "enables");
		end
		$display("random done");
		// A second reset in mid-run returns both registers to zero.
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h2C, 32'h0);
		check(rd, {16'h0000, CONTROL_RST}, "control reset");
		wb(1'b0, 8'h3C, 32'h0);
		check(rd, {16'h0000, STATUS_RST}, "status reset");
		$display("reset done");
		stop_test();
	end
endmodule // tb
`default_nettype wire
